// File: bench/uam_checker.sv
// Purpose: port-level checks of the serial port register interface
// Assumes: zero-wait APB slave, address registers one byte each
// Notes:   shadow copies track the two address registers
`timescale 1ns/10ps
module uam_checker
	import uam_pkg::*;
(
	// clock and reset
	input wire logic              SYS_CLK,
	input wire logic              ARST_N,
	// apb
	input wire logic              PSEL,
	input wire logic              PENABLE,
	input wire logic              PWRITE,
	input wire logic [APB_AW-1:0] PADDR,
	input wire logic [31:0]       PWDATA,
	input wire logic [31:0]       PRDATA,
	input wire logic              PREADY,
	input wire logic              PSLVERR,
	// serial line
	input wire logic              RXD,
	input wire logic              TXD
);
	localparam logic [APB_AW-1:0] A_OWN  = {IDX_OWN_ADDRESS, 2'b00};
	localparam logic [APB_AW-1:0] A_MASK = {IDX_ADDRESS_MASK, 2'b00};
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (!ARST_N);
	logic       acc;
	logic [7:0] own_q;
	logic [7:0] mask_q;
	assign acc = PSEL && PENABLE;
	// shadows start at zero like the real registers
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			own_q  <= 8'h00;
			mask_q <= 8'h00;
		end else if (acc && PWRITE && PADDR == A_OWN) begin
			own_q <= PWDATA[7:0];
		end else if (acc && PWRITE && PADDR == A_MASK) begin
			mask_q <= PWDATA[7:0];
		end
	end
	a_ready_no_wait: assert property (PREADY == acc) else $error("ready not in access phase");
	a_err_in_access: assert property (PSLVERR |-> acc) else $error("error outside access");
	a_unaligned_err: assert property (acc && PADDR[1:0] != 2'b00 |-> PSLVERR)
		else $error("unaligned access accepted");
	a_err_read_zero: assert property (acc && PSLVERR && !PWRITE |-> PRDATA == 32'h0)
		else $error("refused read returned data");
	a_addr_mapped: assert property (acc && (PADDR == A_OWN || PADDR == A_MASK) |-> !PSLVERR)
		else $error("address register refused");
	a_own_readback: assert property (
		acc && !PWRITE && PADDR == A_OWN |-> PRDATA == {24'h0, own_q})
		else $error("own address readback wrong");
	a_mask_readback: assert property (
		acc && !PWRITE && PADDR == A_MASK |-> PRDATA == {24'h0, mask_q})
		else $error("mask readback wrong");
	a_rdata_holds: assert property (acc ##1 !PSEL |-> $stable(PRDATA)) else $error("read data moved");
	a_txd_idle_high: assert property ($rose(ARST_N) |-> TXD) else $error("line not idle after reset");
	// main scenarios
	c_write: cover property (acc && PWRITE);
	c_refused: cover property (acc && PSLVERR);
	c_own_read: cover property (acc && !PWRITE && PADDR == A_OWN);
	c_unaligned: cover property (acc && PADDR[1:0] != 2'b00);
	c_tx_start: cover property ($fell(TXD));
endmodule // uam_checker

bind uam_serial_port uam_checker u_uam_checker (.SYS_CLK(SYS_CLK), .ARST_N(ARST_N), .PSEL(PSEL),
	.PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
	.PREADY(PREADY), .PSLVERR(PSLVERR), .RXD(RXD), .TXD(TXD));

// File: bench/uam_node_model.sv
// Purpose: remote serial node sending frames towards the port
// Assumes: caller enters send just after a rising edge
// Notes:   last low bit is cut one cycle short so a bad stop is no break
`timescale 1ns/10ps
module uam_node_model #(
	parameter int BIT_CYC = 4
) (
	// clock and line
	input wire logic sys_clk,
	output logic     rxd
);
	initial rxd = 1'b1;
	// eleven bits lsb first, then idle high
	task automatic send(input logic [10:0] f);
		for (int i = 0; i < 11; i++) begin
			rxd <= f[i];
			if (!f[i] && (f >> (i + 1)) == (11'h7FF >> (i + 1))) begin
				repeat (BIT_CYC - 1) @(posedge sys_clk);
				rxd <= 1'b1;
				@(posedge sys_clk);
			end else begin
				repeat (BIT_CYC) @(posedge sys_clk);
			end
		end
		rxd <= 1'b1;
		repeat (2 * BIT_CYC) @(posedge sys_clk);
	endtask
endmodule // uam_node_model

// File: bench/uam_serial_port_bench.sv
// Purpose: register-level test of stop check and address match
// Assumes: receive divisor 3, four cycles per bit
// Notes:   frames come from the node model
`timescale 1ns/10ps
module uam_serial_port_bench
	import uam_pkg::*;
;
	localparam logic [9:0] A_PC = {IDX_POWER_CONTROL, 2'b00};
	localparam logic [9:0] A_SC = {IDX_SERIAL_CONTROL, 2'b00};
	localparam logic [9:0] A_SD = {IDX_SERIAL_DATA, 2'b00};
	localparam logic [9:0] A_OWN = {IDX_OWN_ADDRESS, 2'b00};
	localparam logic [9:0] A_MASK = {IDX_ADDRESS_MASK, 2'b00};
	localparam logic [9:0] A_DIV = {IDX_RX_BAUD_DIV, 2'b00};
	localparam logic [9:0] A_TDIV = {IDX_TX_BAUD_DIV, 2'b00};
	// mode-1 frame on the line: start, C3h lsb first, stop
	localparam logic [9:0] TX_FRAME = {1'b1, 8'hC3, 1'b0};
	// control, mask, frame, expected done; own address 56h
	localparam logic [27:0] ROWS [0:10] = '{
		{8'h70, 8'hFC, 2'b11, 8'h55, 2'b01},
		{8'h70, 8'hFC, 2'b11, 8'h5A, 2'b00},
		{8'h70, 8'hFC, 2'b11, 8'hFF, 2'b01},
		{8'h70, 8'hFC, 2'b11, 8'hFE, 2'b01},
		{8'h70, 8'hFC, 2'b10, 8'h55, 2'b00},
		{8'h70, 8'hFF, 2'b11, 8'h57, 2'b00},
		{8'h70, 8'hFF, 2'b11, 8'h56, 2'b01},
		{8'h30, 8'hFF, 2'b11, 8'h5A, 2'b01},
		{8'hF0, 8'hFF, 2'b10, 8'h56, 2'b00},
		{8'hF0, 8'hFF, 2'b11, 8'h56, 2'b01},
		{8'h50, 8'hFF, 2'b11, 8'h5A, 2'b01}};
	logic SYS_CLK, ARST_N, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, TXD, rerr;
	logic [9:0]  PADDR;
	logic [31:0] PWDATA, PRDATA, rdat;
	wire logic   RXD;
	int          fail_count, samples_checked;
	uam_serial_port u_uam_serial_port (.SYS_CLK(SYS_CLK), .ARST_N(ARST_N), .PSEL(PSEL),
		.PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
		.PREADY(PREADY), .PSLVERR(PSLVERR), .RXD(RXD), .TXD(TXD));
	uam_node_model #(.BIT_CYC(4)) u_uam_node_model (.sys_clk(SYS_CLK), .rxd(RXD));
	initial begin
		SYS_CLK = 1'b0;
		forever #12.5 SYS_CLK = ~SYS_CLK;
	end
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// one apb transfer; holds the request until ready is sampled
	task automatic apb(input logic [9:0] a, input logic w, input logic [31:0] d);
		PSEL <= 1'b1;
		PADDR <= a;
		PWRITE <= w;
		PWDATA <= d;
		@(posedge SYS_CLK);
		PENABLE <= 1'b1;
		@(posedge SYS_CLK);
		while (PREADY !== 1'b1) @(posedge SYS_CLK);
		rdat = PRDATA;
		rerr = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
		@(posedge SYS_CLK);
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	// watchdog: the whole run needs about 900 cycles
	initial begin
		repeat (6000) @(posedge SYS_CLK);
		fail_count++;
		test_done();
	end
	initial begin
		{ARST_N, PSEL, PENABLE, PWRITE, PADDR, PWDATA} = '0;
		fail_count = 0;
		samples_checked = 0;
		repeat (3) @(posedge SYS_CLK);
		ARST_N <= 1'b1;
		@(posedge SYS_CLK);
		apb(A_OWN, 1'b0, 32'h0);
		chk("own_address", rdat, 32'h0);
		apb(A_MASK, 1'b0, 32'h0);
		chk("address_mask", rdat, 32'h0);
		apb(10'h3FC, 1'b0, 32'h0);
		chk("unmapped_err", {31'h0, rerr}, 32'h1);
		// an unaligned write is refused and must leave the register alone
		apb(A_OWN + 10'h2, 1'b1, 32'hFF);
		chk("unaligned_err", {31'h0, rerr}, 32'h1);
		apb(A_OWN, 1'b0, 32'h0);
		chk("own_kept", rdat, 32'h0);
		apb(A_DIV, 1'b1, 32'h3);
		apb(A_PC, 1'b1, 32'h40);
		apb(A_SC, 1'b1, 32'h50);
		u_uam_node_model.send({2'b10, 8'hA5, 1'b0});
		apb(A_SC, 1'b0, 32'h0);
		chk("control_bad_stop", rdat, 32'hD1);
		apb(A_SD, 1'b0, 32'h0);
		chk("rx_data", rdat, 32'hA5);
		u_uam_node_model.send({2'b11, 8'h3C, 1'b0});
		apb(A_SC, 1'b0, 32'h0);
		chk("control_sticky", rdat, 32'hD5);
		apb(A_SC, 1'b1, 32'h50);
		apb(A_SC, 1'b0, 32'h0);
		chk("control_cleared", rdat, 32'h50);
		apb(A_PC, 1'b1, 32'h0);
		apb(A_OWN, 1'b1, 32'h56);
		// each row reprograms mode and mask, sends one frame
		for (int i = 0; i < 11; i++) begin
			apb(A_SC, 1'b1, {24'h0, ROWS[i][27:20]});
			apb(A_MASK, 1'b1, {24'h0, ROWS[i][19:12]});
			u_uam_node_model.send(ROWS[i][11:1]);
			apb(A_SC, 1'b0, 32'h0);
			chk("rx_done", {31'h0, rdat[0]}, {31'h0, ROWS[i][0]});
		end
		// transmit one mode-1 frame; each bit is looked at mid-slot, away from shift edges
		apb(A_TDIV, 1'b1, 32'h3);
		apb(A_SD, 1'b1, 32'hC3);
		for (int k = 0; k < 10; k++) begin
			@(posedge SYS_CLK);
			chk("txd_bit", {31'h0, TXD}, {31'h0, TX_FRAME[k]});
			repeat (3) @(posedge SYS_CLK);
		end
		apb(A_SC, 1'b0, 32'h0);
		chk("tx_done", {31'h0, rdat[1]}, 32'h1);
		// reset in mid-run must bring both address registers back to zero
		ARST_N <= 1'b0;
		repeat (2) @(posedge SYS_CLK);
		ARST_N <= 1'b1;
		@(posedge SYS_CLK);
		apb(A_OWN, 1'b0, 32'h0);
		chk("own_after_reset", rdat, 32'h0);
		apb(A_MASK, 1'b0, 32'h0);
		chk("mask_after_reset", rdat, 32'h0);
		test_done();
	end
endmodule // uam_serial_port_bench

// File: hdl/uam_serial_port.sv
// Purpose: serial port with stop-bit check and hardware address match
// Assumes: RXD synchronous to SYS_CLK; bit time = divisor + 1 cycles
// Notes:   mode 0 is simplified to an 8-bit frame, received after a start bit, sent without one
//
// The implementer's own choice: the APB register port.
`timescale 1ns/10ps
module uam_serial_port
	import uam_pkg::*;
#(
	parameter int DIV_W = 16
) (
	// clock and reset
	input  wire logic              SYS_CLK,
	input  wire logic              ARST_N,
	// apb slave
	input  wire logic              PSEL,
	input  wire logic              PENABLE,
	input  wire logic              PWRITE,
	input  wire logic [APB_AW-1:0] PADDR,
	input  wire logic [31:0]       PWDATA,
	output logic      [31:0]       PRDATA,
	output logic                   PREADY,
	output logic                   PSLVERR,
	// serial line
	input  wire logic              RXD,
	output logic                   TXD
);
	if (DIV_W < 4 || DIV_W > 16) begin : g_bad_width
		$error("DIV_W must lie between 4 and 16");
	end

	typedef struct packed {
		logic             mode_select_low;
		logic             mode_select_high;
		logic             multiproc_enable;
		logic             rx_enable;
		logic             tx_ninth;
		logic             rx_ninth;
		logic             transmit_done_flag;
		logic             receive_done_flag;
		logic             framing_error_flag;
		logic             double_baud;
		logic             framing_select;
		logic [7:0]       own_address;
		logic [7:0]       address_mask;
		logic [DIV_W-1:0] rx_div;
		logic [DIV_W-1:0] tx_div;
		logic [7:0]       rx_buf;
		uam_rx_state_t    rx_st;
		logic [DIV_W-1:0] rx_cnt;
		logic [3:0]       rx_bit;
		logic [8:0]       rx_sh;
		logic             tx_busy;
		logic             tx_mode0;
		logic [10:0]      tx_sh;
		logic [3:0]       tx_left;
		logic [DIV_W-1:0] tx_cnt;
		logic             txd;
		logic [31:0]      rdata;
	} uam_state_t;

	uam_state_t st;
	uam_state_t next_st;

	// decoded bus and mode terms
	logic [7:0] idx;
	logic       aligned;
	logic       mapped;
	logic       wr_acc;
	logic [1:0] mode;
	logic       mode23;
	logic       sm_eff;
	logic       at_stop;
	logic [7:0] bcast;
	logic       given_hit;
	logic       bcast_hit;
	logic       addr_hit;
	logic [7:0] sc_read;
	logic [3:0] rx_last;
	logic       deliver;
	logic       accept;
	logic       stop_ok;

	assign idx     = PADDR[9:2];
	assign aligned = (PADDR[1:0] == 2'h0);
	assign mapped  = aligned && (idx == IDX_POWER_CONTROL || idx == IDX_SERIAL_CONTROL
		|| idx == IDX_SERIAL_DATA || idx == IDX_OWN_ADDRESS || idx == IDX_ADDRESS_MASK
		|| idx == IDX_RX_BAUD_DIV || idx == IDX_TX_BAUD_DIV);
	assign wr_acc  = PSEL && PENABLE && PWRITE && mapped;

	// one wait-free access phase; read data was captured during setup
	assign PREADY  = PSEL && PENABLE;
	assign PSLVERR = PSEL && PENABLE && !mapped;
	assign PRDATA  = st.rdata;
	assign TXD     = st.txd;

	assign mode   = {st.mode_select_low, st.mode_select_high};
	assign mode23 = mode[1];
	// multiprocessor features are dead in mode 0
	assign sm_eff = st.multiproc_enable && (mode != 2'h0);
	// decision moves to the stop bit when checking or mode-1 matching
	assign at_stop = (st.framing_select && mode != 2'h0)
		|| (sm_eff && mode == 2'h1);
	assign rx_last = mode23 ? 4'h8 : 4'h7;

	// address recognition on the received byte
	assign bcast     = st.own_address | st.address_mask;
	assign given_hit = ((st.rx_sh[7:0] ^ st.own_address) & st.address_mask) == 8'h00;
	assign bcast_hit = (st.rx_sh[7:0] & bcast) == bcast;
	assign addr_hit  = given_hit || bcast_hit;

	// bit 7 shows the error flag only while framing_select is set
	assign sc_read = {st.framing_select ? st.framing_error_flag : st.mode_select_low,
		st.mode_select_high, st.multiproc_enable, st.rx_enable,
		st.tx_ninth, st.rx_ninth, st.transmit_done_flag, st.receive_done_flag};

	// receiver decision terms, valid in the sample cycle of the frame
	always_comb begin
		deliver = 1'b0;
		stop_ok = RXD;
		if (st.rx_st == RX_DATA && st.rx_cnt == '0 && st.rx_bit == rx_last) begin
			deliver = (mode == 2'h0) || !at_stop;
		end else if (st.rx_st == RX_STOP && st.rx_cnt == '0) begin
			deliver = at_stop;
		end
		// address frames: ninth bit in modes 2/3, stop bit in mode 1
		if (!sm_eff) begin
			accept = 1'b1;
		end else if (mode == 2'h1) begin
			accept = addr_hit && stop_ok;
		end else begin
			// at the ninth-bit sample the bit is still on the line, not yet shifted in
			accept = addr_hit && ((st.rx_st == RX_DATA) ? RXD : st.rx_sh[8]);
		end
	end

	// the whole next state
	always_comb begin
		next_st = st;

		// read data is captured in the setup cycle
		if (PSEL && !PENABLE && !PWRITE && mapped) begin
			case (idx)
				IDX_POWER_CONTROL:  next_st.rdata = {24'h0, st.double_baud, st.framing_select, 6'h0};
				IDX_SERIAL_CONTROL: next_st.rdata = {24'h0, sc_read};
				IDX_SERIAL_DATA:    next_st.rdata = {24'h0, st.rx_buf};
				IDX_OWN_ADDRESS:    next_st.rdata = {24'h0, st.own_address};
				IDX_ADDRESS_MASK:   next_st.rdata = {24'h0, st.address_mask};
				IDX_RX_BAUD_DIV:    next_st.rdata = 32'(st.rx_div);
				IDX_TX_BAUD_DIV:    next_st.rdata = 32'(st.tx_div);
				default:            next_st.rdata = 32'h0;
			endcase
		end else if (PSEL && !PENABLE) begin
			next_st.rdata = 32'h0;
		end

		// software writes first so that hardware sets below win
		if (wr_acc) begin
			case (idx)
				IDX_POWER_CONTROL: begin
					next_st.double_baud    = PWDATA[PC_DOUBLE_BAUD];
					next_st.framing_select = PWDATA[PC_FRAME_SEL];
				end
				IDX_SERIAL_CONTROL: begin
					if (st.framing_select) begin
						next_st.framing_error_flag = PWDATA[SC_MODE_LOW];
					end else begin
						next_st.mode_select_low = PWDATA[SC_MODE_LOW];
					end
					next_st.mode_select_high   = PWDATA[SC_MODE_HIGH];
					next_st.multiproc_enable   = PWDATA[SC_MULTIPROC];
					next_st.rx_enable          = PWDATA[SC_RX_ENABLE];
					next_st.tx_ninth           = PWDATA[SC_TX_NINTH];
					next_st.rx_ninth           = PWDATA[SC_RX_NINTH];
					next_st.transmit_done_flag = PWDATA[SC_TX_DONE];
					next_st.receive_done_flag  = PWDATA[SC_RX_DONE];
				end
				IDX_OWN_ADDRESS:  next_st.own_address  = PWDATA[7:0];
				IDX_ADDRESS_MASK: next_st.address_mask = PWDATA[7:0];
				IDX_RX_BAUD_DIV:  next_st.rx_div = PWDATA[DIV_W-1:0];
				IDX_TX_BAUD_DIV:  next_st.tx_div = PWDATA[DIV_W-1:0];
				default: ;
			endcase
		end

		// receiver, independent of the transmitter below
		case (st.rx_st)
			RX_IDLE: begin
				if (st.rx_enable && !RXD) begin
					next_st.rx_st  = RX_START;
					next_st.rx_cnt = st.rx_div >> 1;
				end
			end
			RX_START: begin
				if (st.rx_cnt != '0) begin
					next_st.rx_cnt = st.rx_cnt - 1'b1;
				end else if (RXD) begin
					// a glitch, not a start bit
					next_st.rx_st = RX_IDLE;
				end else begin
					next_st.rx_st  = RX_DATA;
					next_st.rx_cnt = st.rx_div;
					next_st.rx_bit = 4'h0;
				end
			end
			RX_DATA: begin
				if (st.rx_cnt != '0) begin
					next_st.rx_cnt = st.rx_cnt - 1'b1;
				end else begin
					next_st.rx_sh[st.rx_bit] = RXD;
					next_st.rx_cnt = st.rx_div;
					next_st.rx_bit = st.rx_bit + 4'h1;
					if (st.rx_bit == rx_last) begin
						next_st.rx_st = (mode == 2'h0) ? RX_IDLE : RX_STOP;
					end
				end
			end
			RX_STOP: begin
				if (st.rx_cnt != '0) begin
					next_st.rx_cnt = st.rx_cnt - 1'b1;
				end else begin
					next_st.rx_st = RX_IDLE;
					// without recognition mode 1 keeps the stop bit as ninth bit
					if (mode == 2'h1 && !sm_eff) begin
						next_st.rx_ninth = RXD;
					end
					if (st.framing_select && !RXD) begin
						next_st.framing_error_flag = 1'b1;
					end
				end
			end
			default: next_st.rx_st = RX_IDLE;
		endcase

		// the sample cycle uses the byte assembled so far plus this bit
		if (deliver && accept) begin
			next_st.receive_done_flag = 1'b1;
			next_st.rx_buf = (st.rx_st == RX_DATA && st.rx_bit == 4'h7)
				? {RXD, st.rx_sh[6:0]} : st.rx_sh[7:0];
			if (mode23) begin
				next_st.rx_ninth = (st.rx_st == RX_DATA) ? RXD : st.rx_sh[8];
			end
		end

		// transmitter: write to the data register starts a frame unless one is in progress
		if (wr_acc && idx == IDX_SERIAL_DATA && !st.tx_busy) begin
			next_st.tx_busy  = 1'b1;
			next_st.tx_cnt   = st.tx_div;
			next_st.tx_mode0 = (mode == 2'h0);
			case (mode)
				2'h0: begin
					next_st.tx_sh   = {3'h7, PWDATA[7:0]};
					next_st.tx_left = BITS_MODE0;
				end
				2'h1: begin
					next_st.tx_sh   = {2'h3, PWDATA[7:0], 1'b0};
					next_st.tx_left = BITS_MODE1;
				end
				default: begin
					next_st.tx_sh   = {1'b1, st.tx_ninth, PWDATA[7:0], 1'b0};
					next_st.tx_left = BITS_MODE23;
				end
			endcase
			next_st.txd = next_st.tx_sh[0];
		end else if (st.tx_busy) begin
			if (st.tx_cnt != '0) begin
				next_st.tx_cnt = st.tx_cnt - 1'b1;
			end else begin
				next_st.tx_cnt  = st.tx_div;
				next_st.tx_sh   = {1'b1, st.tx_sh[10:1]};
				next_st.tx_left = st.tx_left - 4'h1;
				next_st.txd     = st.tx_sh[1];
				// done flag at the start of the stop bit, or after bit 8 in mode 0
				if ((st.tx_mode0 && st.tx_left == 4'h1)
					|| (!st.tx_mode0 && st.tx_left == 4'h2)) begin
					next_st.transmit_done_flag = 1'b1;
				end
				if (st.tx_left == 4'h1) begin
					next_st.tx_busy = 1'b0;
					next_st.txd     = 1'b1;
				end
			end
		end
	end

	// all state registered here; reset leaves the line idle high
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			st              <= '0;
			st.own_address  <= RST_ADDRESS;
			st.address_mask <= RST_ADDRESS;
			st.rx_div       <= RST_BAUD_DIV[DIV_W-1:0];
			st.tx_div       <= RST_BAUD_DIV[DIV_W-1:0];
			st.rx_st        <= RX_IDLE;
			st.tx_sh        <= 11'h7FF;
			st.txd          <= 1'b1;
		end else begin
			st <= next_st;
		end
	end
endmodule // uam_serial_port

// File: shared/uam_pkg.sv
// Purpose: constants for the serial receive checker and address matcher
// Assumes: APB word registers, byte address = 4 * register index
// Notes:   indices keep the printed special-function addresses
package uam_pkg;
	localparam int APB_AW = 10;
	// register indices
	localparam logic [7:0] IDX_POWER_CONTROL  = 8'h87;
	localparam logic [7:0] IDX_SERIAL_CONTROL = 8'h98;
	localparam logic [7:0] IDX_SERIAL_DATA    = 8'h99;
	localparam logic [7:0] IDX_OWN_ADDRESS    = 8'hA9;
	localparam logic [7:0] IDX_ADDRESS_MASK   = 8'hB9;
	localparam logic [7:0] IDX_RX_BAUD_DIV    = 8'hC0;
	localparam logic [7:0] IDX_TX_BAUD_DIV    = 8'hC1;
	// serial_control bit positions
	localparam int SC_MODE_LOW  = 7;
	localparam int SC_MODE_HIGH = 6;
	localparam int SC_MULTIPROC = 5;
	localparam int SC_RX_ENABLE = 4;
	localparam int SC_TX_NINTH  = 3;
	localparam int SC_RX_NINTH  = 2;
	localparam int SC_TX_DONE   = 1;
	localparam int SC_RX_DONE   = 0;
	// power_control bit positions
	localparam int PC_DOUBLE_BAUD = 7;
	localparam int PC_FRAME_SEL   = 6;
	// reset values
	localparam logic [7:0]  RST_ADDRESS  = 8'h00;
	localparam logic [15:0] RST_BAUD_DIV = 16'h0015;
	// frame lengths in bits
	localparam logic [3:0] BITS_MODE0  = 4'h8;
	localparam logic [3:0] BITS_MODE1  = 4'hA;
	localparam logic [3:0] BITS_MODE23 = 4'hB;
	// receiver states
	typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} uam_rx_state_t;
endpackage
